// file: logic/sspc_regs.svh
// Constants of the sleep state pin control block.
`ifndef SSPC_REGS_SVH
`define SSPC_REGS_SVH

// ============================================================
// Timing
`define SSPC_CLK_PERIOD_NS 8
`define SSPC_TURN_TIME_NS  16
`define SSPC_TURN_CYCLES   ((`SSPC_TURN_TIME_NS + `SSPC_CLK_PERIOD_NS - 1) / `SSPC_CLK_PERIOD_NS)

// ============================================================
// Reset values
`define SSPC_PIN_OUT_RESET 1'b1
`define SSPC_PIN_OE_RESET  1'b0

`endif

// file: logic/sspc_pkg.sv
// Types of the sleep state pin control block.
package sspc_pkg;
    typedef enum logic [1:0] {
        SSPC_ACTIVE,
        SSPC_SLEEP,
        SSPC_DEEP_SLEEP,
        SSPC_DEEPER_SLEEP
    } sspc_state_type;
endpackage

// file: logic/sspc_power_pin.sv
// Two-way data-input power control pin with drive turnaround.
`timescale 1ns/1ps
`default_nettype none
`include "sspc_regs.svh"
module sspc_power_pin #(
    parameter int TURN_CYCLES = `SSPC_TURN_CYCLES
) (
    input  wire logic clk,
    input  wire logic reset_n,
    input  wire logic switch_active,
    input  wire logic switch_level_n,
    input  wire logic pin_in,
    output var  logic pin_out,
    output var  logic pin_oe,
    output var  logic buffers_reduced
);
    localparam int CW = $clog2(TURN_CYCLES + 1);
    // The pin is released TURN_CYCLES samples after the switch ends.
    localparam int RELEASE_MAX = TURN_CYCLES + 1;

    logic [CW-1:0] hold;

    generate
        if (TURN_CYCLES < 1) begin : g_bad_turn
            $error("TURN_CYCLES must be at least one");
        end
    endgenerate

    // ============================================================
    // Drive control
    // The pin stays driven a little past the switch so the chipset never sees it float mid-change.
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            pin_oe <= `SSPC_PIN_OE_RESET;
            pin_out <= `SSPC_PIN_OUT_RESET;
            hold <= '0;
        end else if (switch_active) begin
            pin_oe <= 1'b1;
            pin_out <= switch_level_n;
            hold <= CW'(TURN_CYCLES);
        end else if (hold != '0) begin
            hold <= hold - CW'(1);
            pin_oe <= (hold != CW'(1));
        end else begin
            pin_oe <= 1'b0;
            pin_out <= `SSPC_PIN_OUT_RESET;
        end
    end

    // ============================================================
    // Buffer power
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            buffers_reduced <= 1'b0;
        end else if (pin_oe) begin
            buffers_reduced <= !pin_out;
        end else begin
            buffers_reduced <= !pin_in;
        end
    end

    chk_drive_on_switch: assert property (@(posedge clk) disable iff (!reset_n)
        switch_active |=> pin_oe)
        else $error("pin not driven during frequency switch");
    chk_release_after_turn: assert property (@(posedge clk) disable iff (!reset_n)
        $fell(switch_active) |-> ##[1:RELEASE_MAX] !pin_oe)
        else $error("pin not released after turnaround");
endmodule
`default_nettype wire

// file: logic/sspc_top.sv
// Sleep state ladder driven by the platform request pins.
`timescale 1ns/1ps
`default_nettype none
`include "sspc_regs.svh"
module sspc_top #(
    parameter int TURN_CYCLES = `SSPC_TURN_CYCLES
) (
    input  wire logic                    clk,
    input  wire logic                    reset_n,
    input  wire logic                    sleep_enter,
    input  wire logic                    deep_sleep_request_n,
    input  wire logic                    deeper_stop_request_n,
    input  wire logic                    freq_switch_active,
    input  wire logic                    freq_switch_level_n,
    input  wire logic                    data_input_power_ctl_n_in,
    output var  logic                    data_input_power_ctl_n_out,
    output var  logic                    data_input_power_ctl_n_oe,
    output var  logic                    input_buffers_reduced,
    output var  sspc_pkg::sspc_state_type sleep_state,
    output var  logic                    in_sleep,
    output var  logic                    in_deep_sleep,
    output var  logic                    in_deeper_sleep,
    output var  logic                    state_changed
);
    import sspc_pkg::*;

    sspc_state_type next_sleep_state;

    // ============================================================
    // State ladder
    // Each request moves the ladder by one step, so a deep request seen in Active waits for Sleep.
    always_comb begin
        next_sleep_state = sleep_state;
        unique case (sleep_state)
            SSPC_ACTIVE: begin
                if (sleep_enter) begin
                    next_sleep_state = SSPC_SLEEP;
                end
            end
            SSPC_SLEEP: begin
                if (!deep_sleep_request_n) begin
                    next_sleep_state = SSPC_DEEP_SLEEP;
                end else if (!sleep_enter) begin
                    next_sleep_state = SSPC_ACTIVE;
                end
            end
            SSPC_DEEP_SLEEP: begin
                if (deep_sleep_request_n) begin
                    next_sleep_state = SSPC_SLEEP;
                end else if (!deeper_stop_request_n) begin
                    next_sleep_state = SSPC_DEEPER_SLEEP;
                end
            end
            SSPC_DEEPER_SLEEP: begin
                if (deeper_stop_request_n) begin
                    next_sleep_state = SSPC_DEEP_SLEEP;
                end
            end
        endcase
    end

    // The request inputs are only ever read, never driven, in this module, because the platform hub owns them.
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            sleep_state <= SSPC_ACTIVE;
        end else begin
            sleep_state <= next_sleep_state;
        end
    end

    // ============================================================
    // Status outputs
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            in_sleep <= 1'b0;
            in_deep_sleep <= 1'b0;
            in_deeper_sleep <= 1'b0;
            state_changed <= 1'b0;
        end else begin
            in_sleep <= (next_sleep_state == SSPC_SLEEP);
            in_deep_sleep <= (next_sleep_state == SSPC_DEEP_SLEEP);
            in_deeper_sleep <= (next_sleep_state == SSPC_DEEPER_SLEEP);
            state_changed <= (next_sleep_state != sleep_state);
        end
    end

    // ============================================================
    // Data-input power control pin
    sspc_power_pin #(
        .TURN_CYCLES (TURN_CYCLES)
    ) u_power_pin (
        .clk             (clk),
        .reset_n         (reset_n),
        .switch_active   (freq_switch_active),
        .switch_level_n  (freq_switch_level_n),
        .pin_in          (data_input_power_ctl_n_in),
        .pin_out         (data_input_power_ctl_n_out),
        .pin_oe          (data_input_power_ctl_n_oe),
        .buffers_reduced (input_buffers_reduced)
    );

    // ============================================================
    // Checks
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!reset_n);

    sequence s_in_deep;
        sleep_state == SSPC_DEEP_SLEEP;
    endsequence

    sequence s_in_deeper;
        sleep_state == SSPC_DEEPER_SLEEP;
    endsequence

    chk_deeper_entry: assert property (
        s_in_deep ##0 (deep_sleep_request_n == 1'b0 && deeper_stop_request_n == 1'b0) |=> s_in_deeper)
        else $error("deeper stop request not honoured in deep sleep");
    chk_deeper_exit: assert property (
        s_in_deeper ##0 deeper_stop_request_n |=> s_in_deep)
        else $error("deeper sleep not left on request release");
    chk_deep_entry: assert property (
        (sleep_state == SSPC_SLEEP && !deep_sleep_request_n) |=> s_in_deep)
        else $error("deep sleep request not honoured in sleep");
    chk_deep_exit: assert property (
        s_in_deep ##0 deep_sleep_request_n |=> sleep_state == SSPC_SLEEP)
        else $error("deep sleep not left on request release");
    chk_deeper_only_deep: assert property (
        (sleep_state != SSPC_DEEP_SLEEP) ##1 s_in_deeper |-> $past(sleep_state) == SSPC_DEEPER_SLEEP)
        else $error("deeper sleep entered from wrong state");
    chk_active_ignores_deep: assert property (
        sleep_state == SSPC_ACTIVE |=> sleep_state inside {SSPC_ACTIVE, SSPC_SLEEP})
        else $error("active skipped a ladder step");
    chk_flags_track_state: assert property (
        in_deeper_sleep == (sleep_state == SSPC_DEEPER_SLEEP) && in_sleep == (sleep_state == SSPC_SLEEP)
        && in_deep_sleep == (sleep_state == SSPC_DEEP_SLEEP))
        else $error("status flags disagree with state");
    chk_pin_listen_idle: assert property (
        (!freq_switch_active) [*4] |-> !data_input_power_ctl_n_oe)
        else $error("power pin driven outside frequency switch");
endmodule
`default_nettype wire

// file: dv/sspc_platform_model.sv
// Platform hub and chipset model for the sleep request pins and power pin.
`timescale 1ns/1ps
`default_nettype none
module sspc_platform_model (
    input  wire logic want_deep,
    input  wire logic want_deeper,
    input  wire logic want_reduce,
    input  wire logic dev_oe,
    input  wire logic dev_out,
    output var  logic deep_sleep_request_n,
    output var  logic deeper_stop_request_n,
    output var  logic pin_level
);
    // =========================================================
    // Request and pin drive
    always_comb begin
        deep_sleep_request_n = ~want_deep;
        deeper_stop_request_n = ~want_deeper;
        // The chipset releases the pin while the device drives it.
        pin_level = dev_oe ? dev_out : ~want_reduce;
    end
endmodule
`default_nettype wire

// file: dv/tb_sleep_state_pin_control.sv
// Self-checking bench for the sleep state ladder and the power pin.
`timescale 1ns/1ps
`default_nettype none
module tb_sleep_state_pin_control;
    import sspc_pkg::*;
    localparam int TURN = 2;
    logic           clk = 1'h0;
    logic           reset_n = 1'h0;
    logic           sleep_enter = 1'h0;
    logic           want_deep = 1'h0;
    logic           want_deeper = 1'h0;
    logic           want_reduce = 1'h0;
    logic           sw_active = 1'h0;
    logic           sw_level_n = 1'h1;
    logic           deep_n;
    logic           deeper_n;
    logic           pin;
    logic           pin_out;
    logic           pin_oe;
    logic           reduced;
    sspc_state_type state;
    logic           in_s;
    logic           in_ds;
    logic           in_dr;
    logic           changed;
    int             failures = 0;
    int             total_checks = 0;
    int             cycles = 0;
    always #4 clk = ~clk;
    sspc_platform_model sspc_platform_model_i (.want_deep(want_deep), .want_deeper(want_deeper),
        .want_reduce(want_reduce), .dev_oe(pin_oe), .dev_out(pin_out), .deep_sleep_request_n(deep_n),
        .deeper_stop_request_n(deeper_n), .pin_level(pin));
    sspc_top #(.TURN_CYCLES(TURN)) sspc_top_i (.clk(clk), .reset_n(reset_n), .sleep_enter(sleep_enter),
        .deep_sleep_request_n(deep_n), .deeper_stop_request_n(deeper_n), .freq_switch_active(sw_active),
        .freq_switch_level_n(sw_level_n), .data_input_power_ctl_n_in(pin), .data_input_power_ctl_n_out(pin_out),
        .data_input_power_ctl_n_oe(pin_oe), .input_buffers_reduced(reduced), .sleep_state(state),
        .in_sleep(in_s), .in_deep_sleep(in_ds), .in_deeper_sleep(in_dr), .state_changed(changed));
    task automatic check(input string what, input logic [2:0] exp, input logic [2:0] got);
        total_checks++;
        if (got !== exp) begin
            failures++;
            $display("mismatch %s expected %0h seen %0h", what, exp, got);
        end
    endtask
    task automatic check_bit(input string what, input logic exp, input logic got);
        check(what, {2'h0, exp}, {2'h0, got});
    endtask
    task automatic step(input int n);
        repeat (n) @(negedge clk);
    endtask
    task automatic expect_state(input sspc_state_type exp);
        check("state", {1'h0, exp}, {1'h0, state});
        check("flags", {exp == SSPC_DEEPER_SLEEP, exp == SSPC_DEEP_SLEEP, exp == SSPC_SLEEP}, {in_dr, in_ds, in_s});
    endtask
    task automatic wrap_up();
        $display("checks %0d failures %0d", total_checks, failures);
        if (failures == 0 && total_checks > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask
    // =========================================================
    // Scenarios
    task automatic t_ladder();
        sleep_enter = 1'h1;
        step(1);
        expect_state(SSPC_SLEEP);
        want_deep = 1'h1;
        step(1);
        expect_state(SSPC_DEEP_SLEEP);
        check_bit("changed", 1'h1, changed);
        want_deeper = 1'h1;
        step(1);
        expect_state(SSPC_DEEPER_SLEEP);
        want_deeper = 1'h0;
        step(1);
        expect_state(SSPC_DEEP_SLEEP);
        want_deep = 1'h0;
        step(1);
        expect_state(SSPC_SLEEP);
        step(1);
        check_bit("changed", 1'h0, changed);
    endtask
    task automatic t_refuse();
        want_deeper = 1'h1;
        step(2);
        expect_state(SSPC_SLEEP);
        want_deeper = 1'h0;
        sleep_enter = 1'h0;
        step(1);
        want_deep = 1'h1;
        step(2);
        expect_state(SSPC_ACTIVE);
        want_deep = 1'h0;
    endtask
    task automatic t_pin();
        want_reduce = 1'h1;
        step(3);
        check_bit("reduced", 1'h1, reduced);
        sw_level_n = 1'h0;
        sw_active = 1'h1;
        want_reduce = 1'h0;
        step(1);
        check_bit("oe", 1'h1, pin_oe);
        check_bit("out", 1'h0, pin_out);
        step(2);
        check_bit("reduced", 1'h1, reduced);
        sw_level_n = 1'h1;
        want_reduce = 1'h1;
        step(3);
        check_bit("reduced", 1'h0, reduced);
        sw_active = 1'h0;
        step(TURN - 1);
        check_bit("oe", 1'h1, pin_oe);
        step(1);
        check_bit("oe", 1'h0, pin_oe);
        check_bit("out", 1'h1, pin_out);
        step(3);
        check_bit("reduced", 1'h1, reduced);
        want_reduce = 1'h0;
        step(3);
        check_bit("reduced", 1'h0, reduced);
    endtask
    task automatic t_priority();
        sleep_enter = 1'h1;
        want_deep = 1'h1;
        want_deeper = 1'h1;
        step(1);
        expect_state(SSPC_SLEEP);
        step(1);
        expect_state(SSPC_DEEP_SLEEP);
        step(1);
        expect_state(SSPC_DEEPER_SLEEP);
        want_deeper = 1'h0;
        step(1);
        expect_state(SSPC_DEEP_SLEEP);
        want_deep = 1'h0;
        want_deeper = 1'h1;
        step(1);
        expect_state(SSPC_SLEEP);
        step(1);
        expect_state(SSPC_SLEEP);
        want_deeper = 1'h0;
        sleep_enter = 1'h0;
        step(1);
        expect_state(SSPC_ACTIVE);
    endtask
    task automatic t_reset();
        sleep_enter = 1'h1;
        want_deep = 1'h1;
        step(2);
        expect_state(SSPC_DEEP_SLEEP);
        sw_level_n = 1'h0;
        sw_active = 1'h1;
        step(1);
        check_bit("oe", 1'h1, pin_oe);
        reset_n = 1'h0;
        step(2);
        expect_state(SSPC_ACTIVE);
        check_bit("changed", 1'h0, changed);
        check_bit("oe", 1'h0, pin_oe);
        check_bit("out", 1'h1, pin_out);
        check_bit("reduced", 1'h0, reduced);
        reset_n = 1'h1;
        sleep_enter = 1'h0;
        want_deep = 1'h0;
        sw_active = 1'h0;
        sw_level_n = 1'h1;
        step(1);
        expect_state(SSPC_ACTIVE);
        check_bit("changed", 1'h0, changed);
        check_bit("oe", 1'h0, pin_oe);
        check_bit("reduced", 1'h0, reduced);
    endtask
    initial begin
        step(16);
        reset_n = 1'h1;
        step(1);
        expect_state(SSPC_ACTIVE);
        check_bit("oe", 1'h0, pin_oe);
        t_ladder();
        t_refuse();
        t_pin();
        t_priority();
        t_reset();
        wrap_up();
    end
    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == 2000) begin
            failures++;
            wrap_up();
        end
    end
endmodule
`default_nettype wire
